// >>> logic/ptcl_map.svh
// register offsets, field positions, code-groups and timing figures of the tx coding block
`ifndef PTCL_MAP_SVH
`define PTCL_MAP_SVH
`define PTCL_AW 10
`define PTCL_DW 16
`define PTCL_OFF_BASIC 10'h000
`define PTCL_OFF_STATUS 10'h011
`define PTCL_OFF_SELFTEST 10'h016
`define PTCL_OFF_SOFTRST 10'h01F
`define PTCL_OFF_TENMEG 10'h02A
`define PTCL_OFF_SWING 10'h30E
`define PTCL_RST_BASIC 16'h0000
`define PTCL_RST_SELFTEST 16'h0000
`define PTCL_RST_TENMEG 16'h0000
`define PTCL_RST_SWING 16'h0000
`define PTCL_SOFT_RST_VAL 16'h4000
`define PTCL_BC_LOOP 14
`define PTCL_BC_SPEED 13
`define PTCL_ST_PCS_IN 0
`define PTCL_ST_PCS_OUT 1
`define PTCL_ST_MII 2
`define PTCL_ST_ANALOG 3
`define PTCL_ST_FAR 4
`define PTCL_ST_DIGITAL 8
`define PTCL_TM_SHORT_PRE 0
`define PTCL_CG_IDLE 5'h1F
`define PTCL_CG_J 5'h18
`define PTCL_CG_K 5'h11
`define PTCL_CG_T 5'h0D
`define PTCL_CG_R 5'h07
`define PTCL_PRE_NIB 4'h5
`define PTCL_CG_LAST 3'h4
`define PTCL_LFSR_SEED 11'h7FF
`define PTCL_LFSR_TAP_A 10
`define PTCL_LFSR_TAP_B 8
`define PTCL_MLT_POS 2'h1
`define PTCL_MLT_NEG 2'h3
`define PTCL_SQ_NEED_RX 3'h2
`define PTCL_SQ_NEED_TX 3'h5
`define PTCL_CLK_MHZ 250
`define PTCL_SQ_MIN_NS 50
`define PTCL_SQ_IDLE_NS 200
`define PTCL_LP_WIDTH_NS 100
`define PTCL_LP_PERIOD_MS 16
`define PTCL_JAB_MS 100
`define PTCL_UNJAB_MS 500
`define PTCL_CNT_W 27
`endif

// >>> logic/ptcl_pkg.sv
// types of the tx coding, 10M link and loopback block
package ptcl_pkg;
`include "ptcl_map.svh"
  typedef enum logic [2:0] {ENC_IDLE, ENC_J, ENC_K, ENC_DATA, ENC_T, ENC_R} ptcl_enc_t;
  typedef enum logic [2:0] {LOOP_NONE, LOOP_PCS_IN, LOOP_PCS_OUT, LOOP_MII, LOOP_ANALOG, LOOP_DIGITAL,
    LOOP_FAR} ptcl_loop_t;
  typedef struct packed {
    logic [`PTCL_DW-1:0] bc;
    logic [`PTCL_DW-1:0] st;
    logic [`PTCL_DW-1:0] tm;
    logic [`PTCL_DW-1:0] os;
    logic [`PTCL_DW-1:0] rdata;
    logic dp_clr;
    ptcl_loop_t loop;
    ptcl_enc_t enc;
    logic [4:0] cg;
    logic [4:0] cg_sh;
    logic bit_div;
    logic [2:0] bit_idx;
    logic nib_take;
    logic [10:0] lfsr;
    logic nrzi;
    logic [1:0] mlt_lvl;
    logic mlt_pos;
    logic mlt_neg;
    logic rx_j_seen;
    logic rx_in_frame;
    logic [3:0] rxd;
    logic rx_dv;
    logic rx_er;
    logic [1:0] rmii_rxd;
    logic rmii_hi;
    logic rmii_dv;
    logic sq_armed;
    logic sq_expect_neg;
    logic sq_first_neg;
    logic [7:0] sq_cnt;
    logic [2:0] sq_qual;
    logic sq_valid;
    logic pol_rev;
    logic rx10_data;
    logic [`PTCL_CNT_W-1:0] lp_cnt;
    logic lp_out;
    logic [`PTCL_CNT_W-1:0] jab_cnt;
    logic jabbed;
    logic tx10_out;
  } ptcl_state_t;
endpackage

// >>> logic/ptcl_top.sv
// tx 4b5b coding, scrambler, nrzi, mlt-3 split, rx decode, 10M link functions and loopback select
//
// Summary of operation
// - each 4-bit MAC nibble becomes a 5-bit code-group toward the line.
// - the first two preamble nibbles of a frame are sent as 11000 then 10001.
// - when the MAC drops TX_EN, 01101 then 00111 follow the last data group.
// - after the end pair, idle groups are sent until TX_EN rises again.
// - data nibbles use the standard 4B5B table; idle group is 11111.
// - control groups other than T, or invalid groups, inside a frame's data raise receive error; T ends the frame.
// - an 11-bit LFSR scrambles the serial code-group stream by XOR.
// - the scrambled stream always goes through the NRZI encoder.
// - scrambled-stream ones alternate between two binary streams, one per driver side.
// - received data leaves as 4-bit MII nibbles and 2-bit RMII dibits.
// - squelch needs opposite crossing 50 ns after first, then original 50 ns later.
// - while transmitting, five qualified transitions are needed, then qualification restarts.
// - at 10M with no transmit, a 100 ns link pulse every 16 ms.
// - jabber cuts 10M transmit after 100 ms of continuous activity.
// - once jabbed, stays off until transmit enable is low for 500 ms.
// - jabber acts only at 10M, never at 100M.
// - reversed 10M receive polarity is found and corrected by hardware.
// - ten_meg_config selects full or short preamble at 10M.
// - at most one loopback mode is active at a time.
// - the four low self-test control bits and bit 8 pick the near-end loopback point.
// - MII loopback needs basic_control bit 14 and self-test bit 2; tx returns on rx.
// - self-test bit 0 is coding input loopback, bit 1 coding output loopback.
`timescale 1ns/1ps
`include "ptcl_map.svh"
module ptcl_top
  import ptcl_pkg::*;
#(
  parameter int LP_PERIOD_CYC = `PTCL_LP_PERIOD_MS * `PTCL_CLK_MHZ * 1000,
  parameter int JAB_CYC = `PTCL_JAB_MS * `PTCL_CLK_MHZ * 1000,
  parameter int UNJAB_CYC = `PTCL_UNJAB_MS * `PTCL_CLK_MHZ * 1000
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [`PTCL_AW-1:0] reg_addr,
  input wire logic [`PTCL_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`PTCL_DW-1:0] reg_rdata,
  input wire logic tx_en,
  input wire logic [3:0] txd,
  output logic tx_nib_take,
  output logic [4:0] tx_cg,
  output logic nrzi_out,
  output logic mlt_pos,
  output logic mlt_neg,
  input wire logic [4:0] rx_cg,
  input wire logic rx_cg_stb,
  output logic [3:0] rxd,
  output logic rx_dv,
  output logic rx_er,
  output logic [1:0] rmii_rxd,
  output logic rmii_crs_dv,
  output logic [2:0] loop_mode,
  input wire logic sq_pos_hit,
  input wire logic sq_neg_hit,
  input wire logic rx10_raw,
  input wire logic ten_tx_en,
  output logic sq_valid,
  output logic pol_rev,
  output logic rx10_data,
  output logic link_pulse,
  output logic tx10_en_out,
  output logic short_pre
);
  localparam logic [7:0] SQ_MIN_CYC = 8'((`PTCL_SQ_MIN_NS * `PTCL_CLK_MHZ + 999) / 1000);
  localparam logic [7:0] SQ_IDLE_CYC = 8'(`PTCL_SQ_IDLE_NS * `PTCL_CLK_MHZ / 1000);
  localparam logic [`PTCL_CNT_W-1:0] LP_WIDTH_CYC = `PTCL_CNT_W'(`PTCL_LP_WIDTH_NS * `PTCL_CLK_MHZ / 1000);
  localparam logic [`PTCL_CNT_W-1:0] LP_LAST = `PTCL_CNT_W'(LP_PERIOD_CYC - 1);
  localparam logic [`PTCL_CNT_W-1:0] JAB_LAST = `PTCL_CNT_W'(JAB_CYC - 1);
  localparam logic [`PTCL_CNT_W-1:0] UNJAB_LAST = `PTCL_CNT_W'(UNJAB_CYC - 1);

  ptcl_state_t s_ff;
  ptcl_state_t nxt_s;
  logic bit_step;
  logic grp;
  logic scr_bit;
  logic speed10;
  logic tx_en_eff;

  // data-path start state; registers and loop select are copied from keep
  function automatic ptcl_state_t dp_init(input ptcl_state_t keep);
    ptcl_state_t r;
    r = '0;
    r.enc = ENC_IDLE;
    r.loop = keep.loop;
    r.cg = `PTCL_CG_IDLE;
    r.cg_sh = `PTCL_CG_IDLE;
    r.lfsr = `PTCL_LFSR_SEED;
    r.bc = keep.bc;
    r.st = keep.st;
    r.tm = keep.tm;
    r.os = keep.os;
    r.rdata = keep.rdata;
    return r;
  endfunction

  function automatic ptcl_state_t reg_init();
    ptcl_state_t r;
    r = '0;
    r.bc = `PTCL_RST_BASIC;
    r.st = `PTCL_RST_SELFTEST;
    r.tm = `PTCL_RST_TENMEG;
    r.os = `PTCL_RST_SWING;
    return dp_init(r);
  endfunction

  function automatic logic [4:0] enc4b5b(input logic [3:0] nib);
    case (nib)
      4'h0: enc4b5b = 5'h1E;
      4'h1: enc4b5b = 5'h09;
      4'h2: enc4b5b = 5'h14;
      4'h3: enc4b5b = 5'h15;
      4'h4: enc4b5b = 5'h0A;
      4'h5: enc4b5b = 5'h0B;
      4'h6: enc4b5b = 5'h0E;
      4'h7: enc4b5b = 5'h0F;
      4'h8: enc4b5b = 5'h12;
      4'h9: enc4b5b = 5'h13;
      4'hA: enc4b5b = 5'h16;
      4'hB: enc4b5b = 5'h17;
      4'hC: enc4b5b = 5'h1A;
      4'hD: enc4b5b = 5'h1B;
      4'hE: enc4b5b = 5'h1C;
      default: enc4b5b = 5'h1D;
    endcase
  endfunction

  // returns {is_data, nibble}
  function automatic logic [4:0] dec5b4b(input logic [4:0] cg);
    dec5b4b = 5'h00;
    for (int i = 0; i < 16; i++)
    begin
      if (enc4b5b(4'(i)) == cg)
      begin
        dec5b4b = {1'b1, 4'(i)};
      end
    end
  endfunction

  // one winner: far end first, then the lowest near-end point
  function automatic ptcl_loop_t loop_pick(input logic [`PTCL_DW-1:0] bc, input logic [`PTCL_DW-1:0] st);
    if (st[`PTCL_ST_FAR])
      loop_pick = LOOP_FAR;
    else if (st[`PTCL_ST_PCS_IN])
      loop_pick = LOOP_PCS_IN;
    else if (st[`PTCL_ST_PCS_OUT])
      loop_pick = LOOP_PCS_OUT;
    else if (st[`PTCL_ST_MII] && bc[`PTCL_BC_LOOP])
      loop_pick = LOOP_MII;
    else if (st[`PTCL_ST_ANALOG])
      loop_pick = LOOP_ANALOG;
    else if (st[`PTCL_ST_DIGITAL])
      loop_pick = LOOP_DIGITAL;
    else
      loop_pick = LOOP_NONE;
  endfunction

  assign bit_step = s_ff.bit_div;
  assign grp = bit_step && (s_ff.bit_idx == `PTCL_CG_LAST);
  assign scr_bit = s_ff.cg_sh[4] ^ s_ff.lfsr[`PTCL_LFSR_TAP_A] ^ s_ff.lfsr[`PTCL_LFSR_TAP_B];
  assign speed10 = !s_ff.bc[`PTCL_BC_SPEED];
  // mac transmit data is ignored in far-end loopback
  assign tx_en_eff = tx_en && (s_ff.loop != LOOP_FAR);

  always_comb
  begin
    logic [4:0] cg_new;
    logic [4:0] dcode;
    logic [4:0] dec_cg;
    logic dec_stb;
    logic hit;
    logic exp_hit;
    logic [2:0] need;
    cg_new = s_ff.cg;
    dcode = 5'h00;
    dec_cg = 5'h00;
    dec_stb = 1'b0;
    hit = 1'b0;
    exp_hit = 1'b0;
    need = 3'h0;
    nxt_s = s_ff;
    nxt_s.dp_clr = 1'b0;
    nxt_s.nib_take = 1'b0;
    nxt_s.rdata = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        `PTCL_OFF_BASIC: nxt_s.rdata = s_ff.bc;
        `PTCL_OFF_SELFTEST: nxt_s.rdata = s_ff.st;
        `PTCL_OFF_TENMEG: nxt_s.rdata = s_ff.tm;
        `PTCL_OFF_SWING: nxt_s.rdata = s_ff.os;
        `PTCL_OFF_STATUS: nxt_s.rdata = `PTCL_DW'({s_ff.jabbed, s_ff.pol_rev, s_ff.sq_valid, s_ff.enc, s_ff.loop});
        default: nxt_s.rdata = '0;
      endcase
    end
    if (reg_wr)
    begin
      case (reg_addr)
        `PTCL_OFF_BASIC: nxt_s.bc = reg_wdata;
        `PTCL_OFF_SELFTEST: nxt_s.st = reg_wdata;
        `PTCL_OFF_TENMEG: nxt_s.tm = reg_wdata;
        `PTCL_OFF_SWING: nxt_s.os = reg_wdata;
        `PTCL_OFF_SOFTRST: nxt_s.dp_clr = (reg_wdata == `PTCL_SOFT_RST_VAL);
        default: nxt_s.dp_clr = 1'b0;
      endcase
    end
    nxt_s.loop = loop_pick(s_ff.bc, s_ff.st);

    // serial chain, one line bit every second clock
    nxt_s.bit_div = !s_ff.bit_div;
    if (bit_step)
    begin
      nxt_s.lfsr = {s_ff.lfsr[9:0], s_ff.lfsr[`PTCL_LFSR_TAP_A] ^ s_ff.lfsr[`PTCL_LFSR_TAP_B]};
      nxt_s.nrzi = s_ff.nrzi ^ scr_bit;
      if (scr_bit)
      begin
        nxt_s.mlt_lvl = s_ff.mlt_lvl + 2'h1;
      end
      nxt_s.mlt_pos = (nxt_s.mlt_lvl == `PTCL_MLT_POS);
      nxt_s.mlt_neg = (nxt_s.mlt_lvl == `PTCL_MLT_NEG);
      nxt_s.bit_idx = s_ff.bit_idx + 3'h1;
      nxt_s.cg_sh = {s_ff.cg_sh[3:0], 1'b0};
    end
    if (grp)
    begin
      nxt_s.nib_take = 1'b1;
      nxt_s.bit_idx = 3'h0;
      case (s_ff.enc)
        ENC_IDLE, ENC_R:
        begin
          nxt_s.enc = tx_en_eff ? ENC_J : ENC_IDLE;
          cg_new = tx_en_eff ? `PTCL_CG_J : `PTCL_CG_IDLE;
        end
        ENC_J:
        begin
          nxt_s.enc = ENC_K;
          cg_new = `PTCL_CG_K;
        end
        ENC_K, ENC_DATA:
        begin
          nxt_s.enc = tx_en_eff ? ENC_DATA : ENC_T;
          cg_new = tx_en_eff ? enc4b5b(txd) : `PTCL_CG_T;
        end
        ENC_T:
        begin
          nxt_s.enc = ENC_R;
          cg_new = `PTCL_CG_R;
        end
        default:
        begin
          nxt_s.enc = ENC_IDLE;
          cg_new = `PTCL_CG_IDLE;
        end
      endcase
      nxt_s.cg = cg_new;
      nxt_s.cg_sh = cg_new;
    end

    // receive decode; coding and digital loopbacks feed it the transmit groups unprocessed
    dec_stb = rx_cg_stb;
    dec_cg = rx_cg;
    if (s_ff.loop inside {LOOP_PCS_IN, LOOP_PCS_OUT, LOOP_DIGITAL})
    begin
      dec_stb = grp;
      dec_cg = cg_new;
    end
    if (s_ff.loop == LOOP_MII && grp)
    begin
      nxt_s.rxd = txd;
      nxt_s.rx_dv = tx_en;
      nxt_s.rx_er = 1'b0;
      nxt_s.rmii_rxd = txd[1:0];
      nxt_s.rmii_hi = 1'b1;
      nxt_s.rmii_dv = tx_en;
    end
    else if (s_ff.loop != LOOP_MII && dec_stb)
    begin
      dcode = dec5b4b(dec_cg);
      nxt_s.rx_j_seen = (dec_cg == `PTCL_CG_J);
      if (!s_ff.rx_in_frame)
      begin
        nxt_s.rx_in_frame = s_ff.rx_j_seen && (dec_cg == `PTCL_CG_K);
        nxt_s.rx_dv = nxt_s.rx_in_frame;
        nxt_s.rxd = `PTCL_PRE_NIB;
        nxt_s.rx_er = 1'b0;
      end
      else if (dec_cg == `PTCL_CG_T)
      begin
        nxt_s.rx_in_frame = 1'b0;
        nxt_s.rx_dv = 1'b0;
        nxt_s.rx_er = 1'b0;
      end
      else
      begin
        nxt_s.rxd = dcode[4] ? dcode[3:0] : 4'h0;
        nxt_s.rx_er = !dcode[4];
      end
      nxt_s.rmii_rxd = nxt_s.rxd[1:0];
      nxt_s.rmii_hi = 1'b1;
      nxt_s.rmii_dv = nxt_s.rx_dv;
    end
    else if (s_ff.rmii_hi)
    begin
      nxt_s.rmii_rxd = s_ff.rxd[3:2];
      nxt_s.rmii_hi = 1'b0;
    end

    // 10M squelch qualification with polarity capture
    hit = sq_pos_hit || sq_neg_hit;
    exp_hit = s_ff.sq_expect_neg ? sq_neg_hit : sq_pos_hit;
    need = ten_tx_en ? `PTCL_SQ_NEED_TX : `PTCL_SQ_NEED_RX;
    nxt_s.sq_cnt = (s_ff.sq_cnt == 8'hFF) ? s_ff.sq_cnt : s_ff.sq_cnt + 8'h01;
    if (!s_ff.sq_armed)
    begin
      if (hit)
      begin
        nxt_s.sq_armed = 1'b1;
        nxt_s.sq_first_neg = sq_neg_hit && !sq_pos_hit;
        nxt_s.sq_expect_neg = !(sq_neg_hit && !sq_pos_hit);
        nxt_s.sq_cnt = 8'h00;
        nxt_s.sq_qual = 3'h0;
      end
      else if (s_ff.sq_valid && s_ff.sq_cnt >= SQ_IDLE_CYC)
      begin
        nxt_s.sq_valid = 1'b0;
      end
    end
    else if (hit)
    begin
      nxt_s.sq_cnt = 8'h00;
      if (exp_hit && s_ff.sq_cnt >= SQ_MIN_CYC - 8'h01)
      begin
        nxt_s.sq_qual = s_ff.sq_qual + 3'h1;
        nxt_s.sq_expect_neg = !s_ff.sq_expect_neg;
        if (nxt_s.sq_qual == need)
        begin
          nxt_s.sq_valid = 1'b1;
          nxt_s.sq_armed = 1'b0;
          nxt_s.pol_rev = s_ff.sq_first_neg;
        end
      end
      else
      begin
        nxt_s.sq_armed = 1'b0;
      end
    end
    nxt_s.rx10_data = rx10_raw ^ s_ff.pol_rev;

    // link pulses while 10M transmit is quiet
    if (speed10 && !ten_tx_en)
    begin
      nxt_s.lp_cnt = (s_ff.lp_cnt == LP_LAST) ? '0 : s_ff.lp_cnt + `PTCL_CNT_W'(1);
      nxt_s.lp_out = (nxt_s.lp_cnt < LP_WIDTH_CYC);
    end
    else
    begin
      nxt_s.lp_cnt = '0;
      nxt_s.lp_out = 1'b0;
    end

    // jabber, counts activity or quiet time depending on state
    if (!speed10)
    begin
      nxt_s.jab_cnt = '0;
      nxt_s.jabbed = 1'b0;
    end
    else if (!s_ff.jabbed)
    begin
      nxt_s.jab_cnt = ten_tx_en ? s_ff.jab_cnt + `PTCL_CNT_W'(1) : '0;
      nxt_s.jabbed = ten_tx_en && (s_ff.jab_cnt == JAB_LAST);
    end
    else
    begin
      nxt_s.jab_cnt = ten_tx_en ? '0 : s_ff.jab_cnt + `PTCL_CNT_W'(1);
      nxt_s.jabbed = !(!ten_tx_en && s_ff.jab_cnt == UNJAB_LAST);
      if (!nxt_s.jabbed)
      begin
        nxt_s.jab_cnt = '0;
      end
    end
    nxt_s.tx10_out = speed10 && ten_tx_en && !nxt_s.jabbed;
    if (s_ff.dp_clr)
    begin
      nxt_s = dp_init(nxt_s);
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      s_ff <= reg_init();
    else
      s_ff <= nxt_s;
  end

  assign reg_rdata = s_ff.rdata;
  assign tx_nib_take = s_ff.nib_take;
  assign tx_cg = s_ff.cg;
  assign nrzi_out = s_ff.nrzi;
  assign mlt_pos = s_ff.mlt_pos;
  assign mlt_neg = s_ff.mlt_neg;
  assign rxd = s_ff.rxd;
  assign rx_dv = s_ff.rx_dv;
  assign rx_er = s_ff.rx_er;
  assign rmii_rxd = s_ff.rmii_rxd;
  assign rmii_crs_dv = s_ff.rmii_dv;
  assign loop_mode = s_ff.loop;
  assign sq_valid = s_ff.sq_valid;
  assign pol_rev = s_ff.pol_rev;
  assign rx10_data = s_ff.rx10_data;
  assign link_pulse = s_ff.lp_out;
  assign tx10_en_out = s_ff.tx10_out;
  assign short_pre = s_ff.tm[`PTCL_TM_SHORT_PRE];

  sequence s_jk;
    tx_cg == `PTCL_CG_J ##10 tx_cg == `PTCL_CG_K;
  endsequence
  sequence s_tr;
    tx_cg == `PTCL_CG_T ##10 tx_cg == `PTCL_CG_R ##10 tx_cg == `PTCL_CG_IDLE;
  endsequence

  property p_start;
    @(posedge clock) disable iff (!rst_n || s_ff.dp_clr)
    (s_ff.enc == ENC_IDLE && grp && tx_en_eff) |=> s_jk;
  endproperty
  a_start: assert property (p_start) else $error("start pair missing");
  property p_end;
    @(posedge clock) disable iff (!rst_n || s_ff.dp_clr)
    (s_ff.enc == ENC_DATA && grp && !tx_en_eff) |=> s_tr;
  endproperty
  a_end: assert property (p_end) else $error("end pair or idle missing");
  property p_data;
    @(posedge clock) disable iff (!rst_n || s_ff.dp_clr)
    (s_ff.enc == ENC_DATA && grp && tx_en_eff) |=> tx_cg == enc4b5b($past(txd));
  endproperty
  a_data: assert property (p_data) else $error("data group wrong");
  property p_nrzi;
    @(posedge clock) disable iff (!rst_n || s_ff.dp_clr)
    bit_step |=> (nrzi_out ^ $past(nrzi_out)) == $past(scr_bit);
  endproperty
  a_nrzi: assert property (p_nrzi) else $error("nrzi not following scrambled bit");
  property p_mlt;
    @(posedge clock) disable iff (!rst_n || s_ff.dp_clr)
    (bit_step && scr_bit && mlt_pos) |=> !mlt_pos && !mlt_neg ##2 !mlt_pos;
  endproperty
  a_mlt: assert property (p_mlt) else $error("mlt-3 did not step to zero");
  property p_jab;
    @(posedge clock) disable iff (!rst_n)
    s_ff.jabbed |=> !tx10_en_out || !$past(s_ff.jabbed);
  endproperty
  a_jab: assert property (p_jab) else $error("transmit on while jabbed");
  property p_jab100;
    @(posedge clock) disable iff (!rst_n)
    !speed10 |=> !s_ff.jabbed && !tx10_en_out;
  endproperty
  a_jab100: assert property (p_jab100) else $error("jabber active at 100M");
  property p_far;
    @(posedge clock) disable iff (!rst_n)
    s_ff.st[`PTCL_ST_FAR] |=> loop_mode == LOOP_FAR;
  endproperty
  a_far: assert property (p_far) else $error("far-end not sole loopback");
  property p_mii;
    @(posedge clock) disable iff (!rst_n || s_ff.dp_clr)
    (s_ff.loop == LOOP_MII && grp) |=> rxd == $past(txd) && rx_dv == $past(tx_en);
  endproperty
  a_mii: assert property (p_mii) else $error("mii loopback data wrong");
  property p_lp;
    @(posedge clock) disable iff (!rst_n)
    $rose(link_pulse) |-> link_pulse [*8];
  endproperty
  a_lp: assert property (p_lp) else $error("link pulse too short");
  property p_soft;
    @(posedge clock) disable iff (!rst_n)
    (reg_wr && reg_addr == `PTCL_OFF_SOFTRST && reg_wdata == `PTCL_SOFT_RST_VAL) |=> ##1
      (s_ff.enc == ENC_IDLE && tx_cg == `PTCL_CG_IDLE);
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset did not restart data path");
endmodule

// >>> test/ptcl_mac.sv
// mac-side transmit model: one preamble-plus-data frame per request
`timescale 1ns/1ps
module ptcl_mac (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic go,
  input wire logic tx_nib_take,
  output logic tx_en,
  output logic [3:0] txd
);
  logic [4:0] idx;
  logic pend;
  // two preamble nibbles, then nibbles 0 to F
  function automatic logic [3:0] nib(input logic [4:0] i);
    return (i < 5'h02) ? 4'h5 : 4'(i - 5'h02);
  endfunction
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      tx_en <= 1'b0;
      txd <= 4'h0;
      idx <= 5'h00;
      pend <= 1'b0;
    end
    else
    begin
      if (go)
        pend <= 1'b1;
      // change only right after a take: nine clocks before the next sample
      if (tx_nib_take && tx_en)
      begin
        idx <= idx + 5'h01;
        txd <= nib(idx + 5'h01);
        if (idx == 5'h11)
          tx_en <= 1'b0;
      end
      else if (tx_nib_take && (pend || go))
      begin
        tx_en <= 1'b1;
        txd <= 4'h5;
        idx <= 5'h00;
        pend <= 1'b0;
      end
    end
  end
endmodule

// >>> test/ptcl_top_test.sv
// self-checking bench of the tx coding, 10M link and loopback block
`timescale 1ns/1ps
`include "ptcl_map.svh"
module ptcl_top_test;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [9:0] reg_addr = 10'h000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [4:0] rx_cg = 5'h00;
  logic rx_cg_stb = 1'b0;
  logic sq_pos_hit = 1'b0;
  logic sq_neg_hit = 1'b0;
  logic rx10_raw = 1'b0;
  logic ten_tx_en = 1'b0;
  logic go = 1'b0;
  logic [15:0] reg_rdata;
  logic tx_en, tx_nib_take, nrzi_out, mlt_pos, mlt_neg, rx_dv, rx_er, rmii_crs_dv;
  logic sq_valid, pol_rev, rx10_data, link_pulse, tx10_en_out, short_pre;
  logic [3:0] txd, rxd;
  logic [4:0] tx_cg;
  logic [1:0] rmii_rxd;
  logic [2:0] loop_mode;
  int mismatches = 0;
  int comparisons = 0;
  localparam logic [4:0] enc_tab [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  localparam logic [9:0] rg [4] = '{`PTCL_OFF_BASIC, `PTCL_OFF_SELFTEST, `PTCL_OFF_TENMEG, `PTCL_OFF_SWING};
  localparam logic [15:0] lp_st [9] = '{16'h0001, 16'h0002, 16'h0004, 16'h0004, 16'h0008, 16'h0010,
    16'h0100, 16'h0013, 16'h0003};
  localparam logic [2:0] lp_ex [9] = '{3'h1, 3'h2, 3'h3, 3'h0, 3'h4, 3'h6, 3'h5, 3'h6, 3'h1};

  ptcl_top #(.LP_PERIOD_CYC(200), .JAB_CYC(100), .UNJAB_CYC(300)) ptcl_top_i (
    .clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_en, .txd, .tx_nib_take,
    .tx_cg, .nrzi_out, .mlt_pos, .mlt_neg, .rx_cg, .rx_cg_stb, .rxd, .rx_dv, .rx_er, .rmii_rxd,
    .rmii_crs_dv, .loop_mode, .sq_pos_hit, .sq_neg_hit, .rx10_raw, .ten_tx_en, .sq_valid, .pol_rev,
    .rx10_data, .link_pulse, .tx10_en_out, .short_pre);
  ptcl_mac ptcl_mac_i (.clock, .rst_n, .go, .tx_nib_take, .tx_en, .txd);

  initial forever #2 clock = ~clock;

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [9:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [9:0] a, input logic [15:0] e, input logic [15:0] m = 16'hFFFF);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata & m, e);
  endtask
  task automatic take();
    int n;
    tick(1);
    for (n = 0; n < 20 && tx_nib_take !== 1'b1; n++)
      tick(1);
    chk(tx_nib_take, 1'b1);
  endtask
  task automatic stb(input logic [4:0] g);
    @(posedge clock);
    rx_cg <= g;
    rx_cg_stb <= 1'b1;
    @(posedge clock);
    rx_cg_stb <= 1'b0;
    #1;
  endtask
  // alternating crossings g cycles apart
  task automatic hits(input logic neg, input int n, input int g);
    int i;
    for (i = 0; i < n; i++)
    begin
      @(posedge clock);
      sq_neg_hit <= neg ^ i[0];
      sq_pos_hit <= ~(neg ^ i[0]);
      @(posedge clock);
      sq_neg_hit <= 1'b0;
      sq_pos_hit <= 1'b0;
      repeat (g - 2) @(posedge clock);
    end
    #1;
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic t_regs();
    int i;
    for (i = 0; i < 4; i++)
    begin
      rdchk(rg[i], 16'h0000);
      wr(rg[i], 16'h1A5C);
      rdchk(rg[i], 16'h1A5C);
      tick(1);
      chk(reg_rdata, 16'h0000);
      wr(rg[i], 16'h0000);
    end
    wr(10'h123, 16'hFFFF);
    rdchk(10'h123, 16'h0000);
    rdchk(`PTCL_OFF_SOFTRST, 16'h0000);
  endtask
  task automatic t_tx();
    int i;
    @(posedge clock) go <= 1'b1;
    @(posedge clock) go <= 1'b0;
    for (i = 0; i < 6 && tx_cg !== `PTCL_CG_J; i++)
      take();
    chk(tx_cg, `PTCL_CG_J);
    take();
    chk(tx_cg, `PTCL_CG_K);
    for (i = 0; i < 16; i++)
    begin
      take();
      chk(tx_cg, enc_tab[i]);
    end
    take();
    chk(tx_cg, `PTCL_CG_T);
    take();
    chk(tx_cg, `PTCL_CG_R);
    for (i = 0; i < 3; i++)
    begin
      take();
      chk(tx_cg, `PTCL_CG_IDLE);
    end
  endtask
  task automatic t_rx();
    logic [3:0] n;
    stb(`PTCL_CG_J);
    stb(`PTCL_CG_K);
    chk(rx_dv, 1'b1);
    chk(rxd, 4'h5);
    chk(rmii_crs_dv, 1'b1);
    for (n = 4'h3; n != 4'h0; n = n + 4'h9)
    begin
      stb(enc_tab[n]);
      chk(rxd, n);
      chk(rmii_rxd, n[1:0]);
      tick(1);
      chk(rmii_rxd, n[3:2]);
    end
    stb(`PTCL_CG_IDLE);
    chk(rx_er, 1'b1);
    chk(rxd, 4'h0);
    stb(`PTCL_CG_T);
    chk(rx_dv, 1'b0);
  endtask
  task automatic t_sq();
    @(posedge clock) rx10_raw <= 1'b1;
    hits(1'b0, 3, 13);
    chk(sq_valid, 1'b1);
    chk(pol_rev, 1'b0);
    chk(rx10_data, 1'b1);
    wr(`PTCL_OFF_SOFTRST, `PTCL_SOFT_RST_VAL);
    hits(1'b1, 3, 13);
    chk(sq_valid, 1'b1);
    chk(pol_rev, 1'b1);
    chk(rx10_data, 1'b0);
    wr(`PTCL_OFF_SOFTRST, `PTCL_SOFT_RST_VAL);
    @(posedge clock) ten_tx_en <= 1'b1;
    hits(1'b0, 3, 13);
    chk(sq_valid, 1'b0);
    hits(1'b1, 3, 13);
    chk(sq_valid, 1'b1);
    wr(`PTCL_OFF_SOFTRST, `PTCL_SOFT_RST_VAL);
    hits(1'b0, 2, 10);
    chk(sq_valid, 1'b0);
    @(posedge clock) ten_tx_en <= 1'b0;
    tick(320);
  endtask
  task automatic t_link();
    int n;
    for (n = 0; n < 40 && link_pulse === 1'b1; n++)
      tick(1);
    for (n = 0; n < 300 && link_pulse !== 1'b1; n++)
      tick(1);
    for (n = 0; n < 40 && link_pulse === 1'b1; n++)
      tick(1);
    chk(16'(n), 16'h0019);
    for (; n < 300 && link_pulse !== 1'b1; n++)
      tick(1);
    chk(16'(n), 16'h00C8);
    @(posedge clock) ten_tx_en <= 1'b1;
    tick(3);
    chk(tx10_en_out, 1'b1);
    tick(110);
    chk(tx10_en_out, 1'b0);
    @(posedge clock) ten_tx_en <= 1'b0;
    tick(150);
    @(posedge clock) ten_tx_en <= 1'b1;
    tick(3);
    chk(tx10_en_out, 1'b0);
    @(posedge clock) ten_tx_en <= 1'b0;
    tick(320);
    @(posedge clock) ten_tx_en <= 1'b1;
    tick(3);
    chk(tx10_en_out, 1'b1);
    wr(`PTCL_OFF_BASIC, 16'h2000);
    tick(150);
    chk(tx10_en_out, 1'b0);
    rdchk(`PTCL_OFF_STATUS, 16'h0000, 16'h0100);
    @(posedge clock) ten_tx_en <= 1'b0;
    wr(`PTCL_OFF_BASIC, 16'h0000);
  endtask
  task automatic t_loop();
    int i;
    for (i = 0; i < 9; i++)
    begin
      wr(`PTCL_OFF_BASIC, (i == 2) ? 16'h4000 : 16'h0000);
      wr(`PTCL_OFF_SELFTEST, lp_st[i]);
      tick(2);
      chk(loop_mode, lp_ex[i]);
      rdchk(`PTCL_OFF_STATUS, lp_ex[i], 16'h0007);
    end
    wr(`PTCL_OFF_SELFTEST, 16'h0000);
  endtask
  task automatic t_dig();
    wr(`PTCL_OFF_BASIC, 16'h2100);
    wr(`PTCL_OFF_SELFTEST, 16'h0104);
    wr(10'h122, 16'h2000);
    wr(10'h123, 16'h2000);
    wr(10'h130, 16'h47FF);
    wr(`PTCL_OFF_SOFTRST, `PTCL_SOFT_RST_VAL);
    tick(5);
    chk(loop_mode, 3'h5);
    chk(tx_cg, `PTCL_CG_IDLE);
    rdchk(`PTCL_OFF_BASIC, 16'h2100);
    rdchk(`PTCL_OFF_SELFTEST, 16'h0104);
    wr(`PTCL_OFF_TENMEG, 16'h0001);
    tick(1);
    chk(short_pre, 1'b1);
  endtask

  always @(negedge clock)
    if (rst_n)
      chk(mlt_pos & mlt_neg, 1'b0);

  initial
  begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    tick(1);
    chk(tx_cg, `PTCL_CG_IDLE);
    t_regs();
    t_tx();
    t_rx();
    t_sq();
    t_link();
    t_loop();
    t_dig();
    give_verdict();
  end
  // about ten times the length of the whole sequence
  initial
  begin
    repeat (20000) @(posedge clock);
    mismatches++;
    give_verdict();
  end
endmodule
